// File: logic/ces_sequencer.sv
// Purpose: Exception processing sequencer with APB register slave
// Assumes: Pipeline, bus and interrupt logic share mclk_i
// Notes:   Frame is two longwords; vector table base is APB mapped
`timescale 1ns/1ps
`default_nettype none
`include "ces_regs.svh"

// Overview of operation
// - First step copies status word, sets supervisor, clears trace.
// - Interrupts also clear master flag and load mask with request level.
// - Fault vectors computed from type; interrupt vectors from acknowledge cycle.
// - Acknowledge cycle uses acknowledge space with level encoded in address.
// - Frame built on shared stack pointer at word aligned top of stack.
// - One fixed frame; stacked PC is faulting or next per type.
// - Handler address read from table base plus four times vector.
// - Processing ends once first handler opcode fetch is acknowledged.
// - Table of 256 longwords; 0-63 architectural, 64-255 user interrupts.
// - Vectors 2,3,4,8,10,11,14 stack the faulting instruction PC.
// - Vectors 9,12,15,24 and 64-255 stack the next instruction PC.
// - Autovectored levels one to seven use vectors 25-31, next PC.
// - Traps 0 to 15 use vectors 32-47, next PC.
// - No interrupt sampling during the first handler instruction.
// - Lower longword: format/vector then status word; upper: saved PC.
// - Format is 4 plus stack pointer low bits; pointer drops 8 to 11.
// - Fault status only for access and address errors, else zero.
// - Fault codes 0100 fetch, 1000 write, 1001 protected, 1100 read.
// - Vector field holds internal number or acknowledge result: value read, autovector or spurious.
// - Table base keeps only upper bits; low 20 bits read zero.
// - Status word: trace 15, supervisor 13, master 12, mask 10:8.
module ces_sequencer
(
   input  wire logic            mclk_i,
   input  wire logic            rst_b_i,
   // Pipeline side
   input  wire logic            exc_valid_i,
   input  wire ces_pkg::ces_exc_s exc_i,
   output logic                 exc_ready_o,
   input  wire logic [15:0]     status_word_i,
   input  wire logic [31:0]     stack_ptr_i,
   output logic [15:0]          status_word_o,
   output logic                 status_load_o,
   output logic [31:0]          stack_ptr_o,
   output logic                 stack_load_o,
   output logic [31:0]          handler_pc_o,
   output logic                 done_o,
   input  wire logic            insn_done_i,
   output logic                 irq_inhibit_o,
   // System bus side
   output ces_pkg::ces_bus_s    bus_o,
   input  wire ces_pkg::ces_rsp_s bus_i,
   // APB slave
   input  wire logic            psel_i,
   input  wire logic            penable_i,
   input  wire logic            pwrite_i,
   input  wire logic [11:0]     paddr_i,
   input  wire logic [31:0]     pwdata_i,
   output logic [31:0]          prdata_o,
   output logic                 pready_o,
   output logic                 pslverr_o
);
   import ces_pkg::*;

   // -----------------------------------------------------------------
   // Vector and PC selection functions
   // -----------------------------------------------------------------
   // Internal vector number for a non-interrupt cause
   function automatic logic [7:0] fault_vector(input ces_kind_e k, input logic [3:0] tn);
      logic [7:0] v;
      v = `CES_VEC_ILLEGAL;
      unique case (k)
         CES_K_ACCESS:  v = `CES_VEC_ACCESS;
         CES_K_ADDRESS: v = `CES_VEC_ADDRESS;
         CES_K_ILLEGAL: v = `CES_VEC_ILLEGAL;
         CES_K_PRIV:    v = `CES_VEC_PRIV;
         CES_K_TRACE:   v = `CES_VEC_TRACE;
         CES_K_LINE_A:  v = `CES_VEC_LINE_A;
         CES_K_LINE_F:  v = `CES_VEC_LINE_F;
         CES_K_DEBUG:   v = `CES_VEC_DEBUG;
         CES_K_FORMAT:  v = `CES_VEC_FORMAT;
         CES_K_TRAP:    v = `CES_VEC_TRAP0 | {4'h0, tn};
         default:       v = `CES_VEC_UNINIT;
      endcase
      return v;
   endfunction

   // True when the vector stacks the faulting instruction PC
   function automatic logic stacks_fault_pc(input logic [7:0] v);
      return (v == `CES_VEC_ACCESS) || (v == `CES_VEC_ADDRESS) ||
             (v == `CES_VEC_ILLEGAL) || (v == `CES_VEC_PRIV) ||
             (v == `CES_VEC_LINE_A) || (v == `CES_VEC_LINE_F) ||
             (v == `CES_VEC_FORMAT);
   endfunction

   // -----------------------------------------------------------------
   // State and captured context
   // -----------------------------------------------------------------
   ces_state_e  state;
   ces_state_e  next_state;
   ces_exc_s    cur;
   logic [15:0] saved_sw;
   logic [31:0] orig_sp;
   logic [7:0]  vector;
   logic [31:0] vtb;
   logic [31:0] ctrl;
   logic [31:0] handler_pc;
   logic        inhibit;

   // Decoded helpers
   wire logic        is_irq     = (cur.kind == CES_K_IRQ);
   wire logic        is_start   = (state == CES_S_IDLE) && exc_valid_i;
   wire logic        bus_done   = bus_o.valid && bus_i.ack;
   wire logic [3:0]  format_val = {`CES_FMT_BASE, orig_sp[1:0]};
   wire logic [31:0] frame_sp   = {orig_sp[31:2], 2'b00} - `CES_FRAME_BYTES;
   wire logic        fs_valid   = (cur.kind == CES_K_ACCESS) ||
                                  (cur.kind == CES_K_ADDRESS);
   wire logic [3:0]  fs_field   = fs_valid ? cur.fault_status : 4'h0;
   wire logic [15:0] fv_word    = {format_val, fs_field[3:2], vector,
                                   fs_field[1:0]};
   wire logic [31:0] stacked_pc = stacks_fault_pc(vector) ?
                                  cur.fault_pc : cur.next_pc;
   wire logic [31:0] vtb_eff    = {vtb[31:`CES_VTB_LSB], 20'h00000};
   wire logic [31:0] vec_addr   = vtb_eff | {22'h000000, vector, 2'b00};
   wire logic [31:0] interrupt_acknowledge_cycle_addr  = {27'h0000000, cur.irq_level, 2'b00};

   // Vector chosen from an acknowledge answer
   wire logic [7:0]  interrupt_acknowledge_cycle_vector = bus_i.err ? `CES_VEC_SPUR :
                                   bus_i.autovec ?
                                   (`CES_VEC_SPUR + {5'h00, cur.irq_level}) :
                                   bus_i.rdata[7:0];

   // New status word after entry
   logic [15:0] next_sw;
   always_comb
   begin
      next_sw = saved_sw;
      next_sw[`CES_SW_SUPER] = 1'b1;
      next_sw[`CES_SW_TRACE] = 1'b0;
      if (is_irq)
      begin
         next_sw[`CES_SW_MASTER] = 1'b0;
         next_sw[`CES_SW_MASK_HI:`CES_SW_MASK_LO] = cur.irq_level;
      end
   end

   // -----------------------------------------------------------------
   // Sequencer next state
   // -----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      unique case (state)
         CES_S_IDLE:  if (exc_valid_i) next_state = CES_S_SAVE;
         CES_S_SAVE:  next_state = is_irq ? CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE : CES_S_PC;
         CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE:  if (bus_done) next_state = CES_S_PC;
         CES_S_PC:    if (bus_done) next_state = CES_S_FV;
         CES_S_FV:    if (bus_done) next_state = CES_S_VREAD;
         CES_S_VREAD: if (bus_done) next_state = CES_S_FETCH;
         CES_S_FETCH: if (bus_done) next_state = CES_S_IDLE;
         default:     next_state = CES_S_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         state <= CES_S_IDLE;
      else
         state <= next_state;
   end

   // Capture of request, status word and stack pointer at entry
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cur      <= '0;
         saved_sw <= 16'h0000;
         orig_sp  <= 32'h0000_0000;
      end
      else if (is_start)
      begin
         cur      <= exc_i;
         saved_sw <= status_word_i;
         orig_sp  <= stack_ptr_i;
      end
   end

   // Vector number: internal or from acknowledge cycle
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         vector <= 8'h00;
      else if (state == CES_S_SAVE && !is_irq)
         vector <= fault_vector(cur.kind, cur.trap_num);
      else if (state == CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE && bus_done)
         vector <= interrupt_acknowledge_cycle_vector;
   end

   // Handler address from vector read
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         handler_pc <= 32'h0000_0000;
      else if (state == CES_S_VREAD && bus_done)
         handler_pc <= bus_i.rdata;
   end

   // Interrupt sampling inhibit through first handler instruction
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         inhibit <= 1'b0;
      else if (state == CES_S_FETCH && bus_done)
         inhibit <= 1'b1;
      else if (insn_done_i)
         inhibit <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Pipeline and bus outputs
   // -----------------------------------------------------------------
   assign exc_ready_o   = (state == CES_S_IDLE);
   assign status_word_o = next_sw;
   assign status_load_o = (state == CES_S_SAVE);
   assign stack_ptr_o   = frame_sp;
   assign stack_load_o  = (state == CES_S_SAVE);
   assign handler_pc_o  = handler_pc;
   assign done_o        = (state == CES_S_FETCH) && bus_done;
   assign irq_inhibit_o = inhibit || (state != CES_S_IDLE);

   // Bus request per state
   always_comb
   begin
      bus_o = '0;
      unique case (state)
         CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE:
         begin
            bus_o.valid = 1'b1;
            bus_o.space = CES_SP_INTERRUPT_ACKNOWLEDGE_CYCLE;
            bus_o.addr  = interrupt_acknowledge_cycle_addr;
         end
         CES_S_PC:
         begin
            bus_o.valid = 1'b1;
            bus_o.write = 1'b1;
            bus_o.addr  = frame_sp + 32'h0000_0004;
            bus_o.wdata = stacked_pc;
         end
         CES_S_FV:
         begin
            bus_o.valid = 1'b1;
            bus_o.write = 1'b1;
            bus_o.addr  = frame_sp;
            bus_o.wdata = {fv_word, saved_sw};
         end
         CES_S_VREAD:
         begin
            bus_o.valid = 1'b1;
            bus_o.addr  = vec_addr;
         end
         CES_S_FETCH:
         begin
            bus_o.valid = 1'b1;
            bus_o.space = CES_SP_FETCH;
            bus_o.addr  = handler_pc;
         end
         default: bus_o = '0;
      endcase
   end

   // -----------------------------------------------------------------
   // APB register slave
   // -----------------------------------------------------------------
   wire logic apb_acc = psel_i && penable_i;
   wire logic hit_vtb = (paddr_i == `CES_OFF_VTB);
   wire logic hit_st  = (paddr_i == `CES_OFF_STAT);
   wire logic hit_ctl = (paddr_i == `CES_OFF_CTRL);
   wire logic hit_any = hit_vtb || hit_st || hit_ctl;
   wire logic [31:0] stat_word = {16'h0000, vector, 3'b000, inhibit,
                                  1'b0, state};

   assign pready_o  = 1'b1;
   assign pslverr_o = apb_acc && !hit_any;
   assign prdata_o  = hit_vtb ? vtb_eff :
                      hit_st  ? stat_word :
                      hit_ctl ? ctrl : 32'h0000_0000;

   // Writable registers
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         vtb  <= `CES_VTB_RST;
         ctrl <= `CES_CTRL_RST;
      end
      else if (apb_acc && pwrite_i)
      begin
         if (hit_vtb)
            vtb <= {pwdata_i[31:`CES_VTB_LSB], 20'h00000};
         if (hit_ctl)
            ctrl <= pwdata_i;
      end
   end

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   a_entry_status: assert property (status_load_o |->
      status_word_o[`CES_SW_SUPER] && !status_word_o[`CES_SW_TRACE])
      else $error("entry status word not supervisor without trace");
   a_irq_mask_load: assert property (status_load_o && is_irq |->
      !status_word_o[`CES_SW_MASTER] &&
      status_word_o[`CES_SW_MASK_HI:`CES_SW_MASK_LO] == cur.irq_level)
      else $error("interrupt entry mask or master flag wrong");
   a_interrupt_acknowledge_cycle_level: assert property (state == CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE |->
      bus_o.space == CES_SP_INTERRUPT_ACKNOWLEDGE_CYCLE &&
      bus_o.addr[4:`CES_INTERRUPT_ACKNOWLEDGE_CYCLE_LVL_LSB] == cur.irq_level)
      else $error("acknowledge cycle lacks level or space");
   a_frame_align: assert property (stack_load_o |->
      stack_ptr_o[1:0] == 2'b00 &&
      orig_sp - stack_ptr_o == 32'h0000_0008 + {30'h0, orig_sp[1:0]})
      else $error("frame pointer not word aligned");
   a_fault_pc_sel: assert property (state == CES_S_PC &&
      stacks_fault_pc(vector) |-> bus_o.wdata == cur.fault_pc)
      else $error("fault vector stacked wrong PC");
   a_next_pc_sel: assert property (state == CES_S_PC &&
      !stacks_fault_pc(vector) |-> bus_o.wdata == cur.next_pc)
      else $error("next instruction vector stacked wrong PC");
   a_format_value: assert property (state == CES_S_FV |->
      bus_o.wdata[31:28] == 4'h4 + {2'b00, orig_sp[1:0]})
      else $error("format field does not follow stack pointer");
   a_fs_zeroed: assert property (state == CES_S_FV && !fs_valid |->
      bus_o.wdata[27:26] == 2'b00 && bus_o.wdata[17:16] == 2'b00)
      else $error("fault status not zero for this cause");
   a_write_order: assert property (state == CES_S_FV && bus_done |=>
      state == CES_S_VREAD && bus_o.addr == vec_addr)
      else $error("vector read not right after frame writes");
   a_bus_hold: assert property (bus_o.valid && !bus_i.ack |=>
      $stable(bus_o))
      else $error("bus request changed before acknowledge");
   a_table_addr: assert property (state == CES_S_VREAD |->
      bus_o.addr[31:20] == vtb[31:20] && bus_o.addr[19:10] == 10'h000 &&
      bus_o.addr[9:0] == {vector, 2'b00})
      else $error("vector table read address wrong");
   a_vtb_low_zero: assert property (psel_i && hit_vtb |->
      prdata_o[19:0] == 20'h00000)
      else $error("table base low bits not zero");
   a_inhibit_after: assert property (done_o |=> irq_inhibit_o [*2])
      else $error("interrupts sampled right after handler entry");
   a_fetch_target: assert property (state == CES_S_FETCH |->
      bus_o.space == CES_SP_FETCH && bus_o.addr == handler_pc_o)
      else $error("handler fetch not at fetched vector");
   a_trap_vector: assert property (state == CES_S_SAVE &&
      cur.kind == CES_K_TRAP |=> vector == {4'h2, cur.trap_num})
      else $error("trap vector not in range 32-47");
   a_autovec: assert property (state == CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE && bus_done &&
      !bus_i.err && bus_i.autovec |=>
      vector == 8'h18 + {5'h00, cur.irq_level})
      else $error("autovector number wrong");
   a_spur_vector: assert property (state == CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE && bus_done &&
      bus_i.err |=> vector == 8'h18)
      else $error("unanswered acknowledge not spurious");

   c_irq_done:   cover property (is_irq && done_o);
   c_trap_done:  cover property (cur.kind == CES_K_TRAP && done_o);
   c_autovec:    cover property (state == CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE && bus_done && bus_i.autovec);
   c_odd_sp:     cover property (stack_load_o && orig_sp[1:0] == 2'b11);
   c_spurious:   cover property (state == CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE && bus_done && bus_i.err);

endmodule
`default_nettype wire

// File: inc/ces_regs.svh
// Purpose: Constants for the core exception sequencer
// Assumes: APB word offsets, 32-bit data
// Notes:   Definitions only
`ifndef CES_REGS_SVH
`define CES_REGS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define CES_OFF_VTB      12'h000
`define CES_OFF_STAT     12'h004
`define CES_OFF_CTRL     12'h008

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define CES_SW_TRACE     15
`define CES_SW_SUPER     13
`define CES_SW_MASTER    12
`define CES_SW_MASK_HI   10
`define CES_SW_MASK_LO   8
`define CES_VTB_LSB      20
`define CES_VTB_RST      32'h0000_0000
`define CES_CTRL_RST     32'h0000_0000
`define CES_INTERRUPT_ACKNOWLEDGE_CYCLE_LVL_LSB 2

// -----------------------------------------------------------------
// Vector numbers
// -----------------------------------------------------------------
`define CES_VEC_ACCESS   8'h02
`define CES_VEC_ADDRESS  8'h03
`define CES_VEC_ILLEGAL  8'h04
`define CES_VEC_PRIV     8'h08
`define CES_VEC_TRACE    8'h09
`define CES_VEC_LINE_A   8'h0a
`define CES_VEC_LINE_F   8'h0b
`define CES_VEC_DEBUG    8'h0c
`define CES_VEC_FORMAT   8'h0e
`define CES_VEC_UNINIT   8'h0f
`define CES_VEC_SPUR     8'h18
`define CES_VEC_TRAP0    8'h20
`define CES_VEC_USER0    8'h40
`define CES_FRAME_BYTES  32'h0000_0008
`define CES_FMT_BASE     2'b01

`endif

// File: inc/ces_pkg.sv
// Purpose: Types for the core exception sequencer
// Assumes: Single core clock
// Notes:   Constants live in ces_regs.svh
`default_nettype none
package ces_pkg;

   // Exception causes from the pipeline
   typedef enum logic [3:0] {
      CES_K_ACCESS  = 4'h0,
      CES_K_ADDRESS = 4'h1,
      CES_K_ILLEGAL = 4'h2,
      CES_K_PRIV    = 4'h3,
      CES_K_TRACE   = 4'h4,
      CES_K_LINE_A  = 4'h5,
      CES_K_LINE_F  = 4'h6,
      CES_K_DEBUG   = 4'h7,
      CES_K_FORMAT  = 4'h8,
      CES_K_TRAP    = 4'h9,
      CES_K_IRQ     = 4'ha
   } ces_kind_e;

   // Sequencer states
   typedef enum logic [2:0] {
      CES_S_IDLE  = 3'b000,
      CES_S_SAVE  = 3'b001,
      CES_S_INTERRUPT_ACKNOWLEDGE_CYCLE  = 3'b010,
      CES_S_PC    = 3'b011,
      CES_S_FV    = 3'b100,
      CES_S_VREAD = 3'b101,
      CES_S_FETCH = 3'b110
   } ces_state_e;

   // Bus address spaces
   typedef enum logic [1:0] {
      CES_SP_DATA  = 2'b00,
      CES_SP_INTERRUPT_ACKNOWLEDGE_CYCLE  = 2'b01,
      CES_SP_FETCH = 2'b10
   } ces_space_e;

   // Exception request from the pipeline
   typedef struct packed {
      ces_kind_e   kind;
      logic [3:0]  trap_num;
      logic [2:0]  irq_level;
      logic [3:0]  fault_status;
      logic [31:0] fault_pc;
      logic [31:0] next_pc;
   } ces_exc_s;

   // System bus request
   typedef struct packed {
      logic        valid;
      logic        write;
      ces_space_e  space;
      logic [31:0] addr;
      logic [31:0] wdata;
   } ces_bus_s;

   // System bus response
   typedef struct packed {
      logic        ack;
      logic        err;
      logic        autovec;
      logic [31:0] rdata;
   } ces_rsp_s;

endpackage
`default_nettype wire

// File: dv/ces_bus_model.sv
// Purpose: System bus and interrupting peripheral model for the sequencer
// Assumes: One request at a time, answered after wait_i stall cycles
// Notes:   Records frame writes and read addresses for the bench
`timescale 1ns/1ps
`default_nettype none
module ces_bus_model
   import ces_pkg::*;
(
   input  wire logic              mclk_i,
   input  wire logic              rst_b_i,
   input  wire ces_pkg::ces_bus_s bus_i,
   output ces_pkg::ces_rsp_s      rsp_o,
   input  wire logic [1:0]        wait_i,
   input  wire logic [1:0]        mode_i,
   input  wire logic [2:0]        lvl_i,
   input  wire logic [7:0]        vec_i
);
   logic [1:0]  cnt;
   logic [1:0]  nwr;
   logic [1:0]  wr_at_rd;
   logic        ack;
   logic [31:0] last;
   logic [31:0] pc_a, pc_d, fv_a, fv_d, vr_a, ia_a, ft_a;

   // -----------------------------------------------------------------
   // Answer
   // -----------------------------------------------------------------
   // Ack after the stall count; idle read data is never the last value
   assign ack = bus_i.valid && (cnt >= wait_i);
   always_comb
   begin
      rsp_o = '{ack: ack, err: 1'b0, autovec: 1'b0, rdata: ~last};
      if (ack && !bus_i.write)
      begin
         if (bus_i.space == CES_SP_INTERRUPT_ACKNOWLEDGE_CYCLE)
         begin
            // Only the peripheral at the encoded level answers
            rsp_o.err     = (mode_i == 2'h2) || (bus_i.addr[4:2] != lvl_i);
            rsp_o.autovec = (mode_i == 2'h1);
            rsp_o.rdata   = {24'h000000, vec_i};
         end
         else
            rsp_o.rdata = ~bus_i.addr;
      end
   end

   // Capture of the completed transfers
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cnt  <= 2'h0;
         nwr  <= 2'h0;
         last <= 32'h00000000;
      end
      else
      begin
         cnt <= (bus_i.valid && !ack) ? cnt + 2'h1 : 2'h0;
         if (ack && bus_i.write)
         begin
            nwr <= nwr + 2'h1;
            if (nwr == 2'h0)
               {pc_a, pc_d} <= {bus_i.addr, bus_i.wdata};
            else
               {fv_a, fv_d} <= {bus_i.addr, bus_i.wdata};
         end
         else if (ack)
         begin
            last <= rsp_o.rdata;
            if (bus_i.space == CES_SP_INTERRUPT_ACKNOWLEDGE_CYCLE)
               ia_a <= bus_i.addr;
            else if (bus_i.space == CES_SP_FETCH)
               {ft_a, nwr} <= {bus_i.addr, 2'h0};
            else
               {vr_a, wr_at_rd} <= {bus_i.addr, nwr};
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/ces_sequencer_tb.sv
// Purpose: Self-checking bench for the exception sequencer
// Assumes: 100 MHz clock, zero-wait APB slave
// Notes:   Each scenario task drives and judges its own traffic
`timescale 1ns/1ps
`default_nettype none
`include "ces_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
   $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module ces_sequencer_tb;
   import ces_pkg::*;
   logic mclk_i, rst_b_i, exc_valid_i, insn_done_i, psel_i, penable_i, pwrite_i;
   logic exc_ready_o, status_load_o, stack_load_o, done_o, irq_inhibit_o;
   logic prdata_ok, pready_o, pslverr_o;
   logic [1:0] wt, md;
   logic [7:0] pv;
   logic [11:0] paddr_i;
   logic [15:0] status_word_o;
   logic [31:0] stack_ptr_i, stack_ptr_o, handler_pc_o, pwdata_i, prdata_o, rd;
   ces_exc_s exc_i;
   ces_bus_s bus_o;
   ces_rsp_s bus_i;
   int fails = 0;
   int check_count = 0;
   ces_kind_e fk[7] = '{CES_K_ACCESS, CES_K_ADDRESS, CES_K_ILLEGAL, CES_K_PRIV,
                        CES_K_LINE_A, CES_K_LINE_F, CES_K_FORMAT};
   logic [7:0] fvn[7] = '{8'h02, 8'h03, 8'h04, 8'h08, 8'h0a, 8'h0b, 8'h0e};
   logic [3:0] fc[4] = '{4'h4, 4'h8, 4'h9, 4'hc};
   localparam logic [15:0] SW = 16'h951f;
   localparam logic [31:0] VTB = 32'h00300000;

   ces_sequencer ces_sequencer_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .exc_valid_i(exc_valid_i), .exc_i(exc_i), .exc_ready_o(exc_ready_o),
      .status_word_i(SW), .stack_ptr_i(stack_ptr_i), .status_word_o(status_word_o),
      .status_load_o(status_load_o), .stack_ptr_o(stack_ptr_o), .stack_load_o(stack_load_o),
      .handler_pc_o(handler_pc_o), .done_o(done_o), .insn_done_i(insn_done_i),
      .irq_inhibit_o(irq_inhibit_o), .bus_o(bus_o), .bus_i(bus_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
   ces_bus_model ces_bus_model_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_i(bus_o),
      .rsp_o(bus_i), .wait_i(wt), .mode_i(md), .lvl_i(exc_i.irq_level), .vec_i(pv));

   // -----------------------------------------------------------------
   // Clock, reset and watchdog
   // -----------------------------------------------------------------
   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   initial
   begin
      #100000;
      fails++;
      close_out();
   end

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One APB transfer; data and error taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, 1'b0, w, a, d};
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      {rd, prdata_ok} = {prdata_o, pslverr_o};
      {psel_i, penable_i} <= 2'b00;
   endtask

   // -----------------------------------------------------------------
   // One exception, judged from entry to the handler's first insn
   // -----------------------------------------------------------------
   task automatic do_exc(input ces_kind_e k, input logic [3:0] t, input logic [2:0] l,
      input logic [3:0] fs, input logic [31:0] sp, input logic [7:0] ev, input logic f);
      logic [31:0] spn;
      logic [15:0] esw;
      logic [3:0] efs;
      spn = {sp[31:2], 2'b00} - 32'h8;
      esw = (SW | 16'h2000) & 16'h7fff;
      if (k == CES_K_IRQ)
         esw = {esw[15:13], 1'b0, esw[11], l, esw[7:0]};
      efs = (k == CES_K_ACCESS || k == CES_K_ADDRESS) ? fs : 4'h0;
      @(posedge mclk_i);
      exc_valid_i <= 1'b1;
      exc_i <= '{kind: k, trap_num: t, irq_level: l, fault_status: fs,
                 fault_pc: 32'h00001230, next_pc: 32'h00001234};
      stack_ptr_i <= sp;
      @(posedge mclk_i);
      exc_valid_i <= 1'b0;
      #1;
      `CHK({status_load_o, stack_load_o}, 2'b11)
      `CHK(status_word_o, esw)
      `CHK(stack_ptr_o, spn)
      `CHK({exc_ready_o, done_o}, 2'b00)
      for (int n = 0; n < 100 && done_o !== 1'b1; n++) @(negedge mclk_i);
      `CHK(done_o, 1'b1)
      @(negedge mclk_i);
      `CHK({ces_bus_model_inst.pc_a, ces_bus_model_inst.pc_d},
           {spn + 32'h4, f ? 32'h00001230 : 32'h00001234})
      `CHK({ces_bus_model_inst.fv_a, ces_bus_model_inst.fv_d},
           {spn, 4'h4 + {2'b00, sp[1:0]}, efs[3:2], ev, efs[1:0], SW})
      `CHK(ces_bus_model_inst.vr_a, VTB | {22'h0, ev, 2'b00})
      `CHK(ces_bus_model_inst.wr_at_rd, 2'h2)
      `CHK({ces_bus_model_inst.ft_a, handler_pc_o}, {2{~(VTB | {22'h0, ev, 2'b00})}})
      if (k == CES_K_IRQ)
         `CHK(ces_bus_model_inst.ia_a[4:2], l)
      `CHK(irq_inhibit_o, 1'b1)
      @(posedge mclk_i);
      insn_done_i <= 1'b1;
      @(posedge mclk_i);
      insn_done_i <= 1'b0;
      @(negedge mclk_i);
      `CHK(irq_inhibit_o, 1'b0)
      `CHK(exc_ready_o, 1'b1)
   endtask

   // Table base reset, upper bits only, unmapped refusal
   task automatic reg_test();
      apb(1'b0, `CES_OFF_VTB, 32'h0);
      `CHK(rd, 32'h00000000)
      apb(1'b1, `CES_OFF_VTB, 32'hfedcba98);
      apb(1'b0, `CES_OFF_VTB, 32'h0);
      `CHK(rd, 32'hfed00000)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK({prdata_ok, rd}, {1'b1, 32'h00000000})
      apb(1'b1, `CES_OFF_VTB, VTB);
   endtask

   // Faulting-PC vectors with every fault status code
   task automatic fault_test();
      md = 2'h0;
      for (int i = 0; i < 4; i++)
      begin
         wt = i[1:0];
         do_exc(CES_K_ADDRESS, 4'h0, 3'h0, fc[i], 32'h00010000 + i, 8'h03, 1'b1);
      end
      for (int i = 0; i < 7; i++)
         do_exc(fk[i], 4'h0, 3'h0, fc[i % 4], 32'h00020000 + i, fvn[i], 1'b1);
   endtask

   // Next-PC vectors: trace, debug, traps at both ends
   task automatic next_test();
      wt = 2'h1;
      do_exc(CES_K_TRACE, 4'h0, 3'h0, 4'h4, 32'h00030001, 8'h09, 1'b0);
      do_exc(CES_K_DEBUG, 4'h0, 3'h0, 4'h0, 32'h00030002, 8'h0c, 1'b0);
      do_exc(CES_K_TRAP, 4'h0, 3'h0, 4'h0, 32'h00030003, 8'h20, 1'b0);
      do_exc(CES_K_TRAP, 4'hf, 3'h0, 4'h0, 32'h00030000, 8'h2f, 1'b0);
   endtask

   // Interrupts: autovectors, supplied vectors, no answer
   task automatic irq_test();
      md = 2'h1;
      for (int i = 1; i < 8; i++)
      begin
         wt = i[1:0];
         do_exc(CES_K_IRQ, 4'h0, i[2:0], 4'h0, 32'h00040000 + i, 8'h18 + i[7:0], 1'b0);
      end
      md = 2'h0;
      pv = 8'h40;
      do_exc(CES_K_IRQ, 4'h0, 3'h3, 4'h0, 32'h00050000, 8'h40, 1'b0);
      pv = 8'hff;
      do_exc(CES_K_IRQ, 4'h0, 3'h7, 4'h0, 32'h00050003, 8'hff, 1'b0);
      pv = 8'h0f;
      do_exc(CES_K_IRQ, 4'h0, 3'h1, 4'h0, 32'h00050001, 8'h0f, 1'b0);
      md = 2'h2;
      do_exc(CES_K_IRQ, 4'h0, 3'h5, 4'h0, 32'h00050002, 8'h18, 1'b0);
   endtask

   initial
   begin
      {rst_b_i, exc_valid_i, insn_done_i, psel_i, penable_i, pwrite_i} = 6'h00;
      {paddr_i, pwdata_i, stack_ptr_i, wt, md, pv} = '0;
      exc_i = '0;
      repeat (6) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(negedge mclk_i);
      `CHK({exc_ready_o, irq_inhibit_o, bus_o.valid}, 3'b100)
      reg_test();
      fault_test();
      next_test();
      irq_test();
      close_out();
   end
endmodule
`default_nettype wire
